//--- logic/queue_flag_pkg.sv
`default_nettype none
package queue_flag_pkg;
   // ==========================================================
   // device geometry
   localparam int QUEUES = 32;
   localparam int QUEUE_W = 5;
   localparam int ID_W = 3;
   localparam int ADDR_W = 8;
   localparam int QUAD_W = 2;
   localparam int BUS_W = 8;
   localparam int QCNT_W = 6;
   localparam int CNT_W = 13;
   localparam int DEPTH_DEFAULT = 2048;
   localparam logic [QCNT_W-1:0] DEDICATED_MAX = 6'h08;

   // ==========================================================
   // default offsets picked by the strap at master reset
   localparam logic [CNT_W-1:0] OFFSET_LOW = 13'h0008;
   localparam logic [CNT_W-1:0] OFFSET_HIGH = 13'h0080;

   // input width to output width pairing
   typedef enum logic [1:0] {
      MATCH_EQUAL,
      MATCH_IN18_OUT9,
      MATCH_IN9_OUT18
   } bus_match_t;

   // ==========================================================
   // controller register map, byte offsets
   localparam logic [7:0] REG_COMMAND = 8'h00;
   localparam logic [7:0] REG_CONFIG = 8'h04;
   localparam logic [7:0] REG_FLAGS = 8'h08;
   localparam logic [7:0] REG_BUSES = 8'h0C;
   localparam int CMD_ADDR_LSB = 0;
   localparam int CMD_OP_LSB = 8;
   localparam int CFG_RESET_BIT = 0;
   localparam int CFG_DF_BIT = 1;
   localparam int CFG_FM_BIT = 2;
   localparam int CFG_MATCH_LSB = 3;
   localparam int CFG_QCNT_LSB = 5;
   localparam logic [31:0] CONFIG_RESET = 32'h0000_0401;

   // one link cycle per command word; OP_WRITE_AND_QUAD writes and strobes the quadrant together
   typedef enum logic [2:0] {
      OP_NONE,
      OP_WRITE_SELECT,
      OP_FULL_QUAD,
      OP_WRITE,
      OP_READ_SELECT,
      OP_READ,
      OP_EMPTY_QUAD,
      OP_WRITE_AND_QUAD
   } cmd_op_t;
endpackage
`default_nettype wire

//--- logic/queue_flag_if.sv
`timescale 1ns/1ns
`default_nettype none
interface queue_flag_if;
   import queue_flag_pkg::*;
   // ==========================================================
   // configuration sampled at master reset
   logic masterResetN;
   logic defaultOffsetSelect;
   logic flagBusModeSelect;
   bus_match_t busMatch;
   logic [QCNT_W-1:0] queueCount;
   // write port
   logic [ADDR_W-1:0] writeQueueAddr;
   logic writeAddrEnable;
   logic writeEnable;
   logic fullQuadStrobe;
   // read port
   logic [ADDR_W-1:0] readQueueAddr;
   logic readAddrEnable;
   logic readEnable;
   logic emptyQuadStrobe;
   // flags and status buses active low, bus enables active high
   logic queueFullFlagN;
   logic almostFullFlagN;
   logic almostEmptyFlagN;
   logic [BUS_W-1:0] almostFullStatusBusN;
   logic almostFullBusOe;
   logic [BUS_W-1:0] almostEmptyStatusBusN;
   logic almostEmptyBusOe;

   modport device (
      input masterResetN, defaultOffsetSelect, flagBusModeSelect,
      input busMatch, queueCount,
      input writeQueueAddr, writeAddrEnable, writeEnable, fullQuadStrobe,
      input readQueueAddr, readAddrEnable, readEnable, emptyQuadStrobe,
      output queueFullFlagN, almostFullFlagN, almostEmptyFlagN,
      output almostFullStatusBusN, almostFullBusOe,
      output almostEmptyStatusBusN, almostEmptyBusOe
   );
   modport host (
      output masterResetN, defaultOffsetSelect, flagBusModeSelect,
      output busMatch, queueCount,
      output writeQueueAddr, writeAddrEnable, writeEnable, fullQuadStrobe,
      output readQueueAddr, readAddrEnable, readEnable, emptyQuadStrobe,
      input queueFullFlagN, almostFullFlagN, almostEmptyFlagN,
      input almostFullStatusBusN, almostFullBusOe,
      input almostEmptyStatusBusN, almostEmptyBusOe
   );
endinterface
`default_nettype wire

//--- logic/queue_flag_counter.sv
`timescale 1ns/1ns
`default_nettype none
module queue_flag_counter
   import queue_flag_pkg::*;
#(
   parameter int DEPTH = DEPTH_DEFAULT
) (
   // clock and reset
   input wire logic clk_sys,
   input wire logic srst,
   input wire logic clear,
   // configuration
   input wire bus_match_t busMatch,
   input wire logic [CNT_W-1:0] afOffset,
   input wire logic [CNT_W-1:0] aeOffset,
   // traffic to this queue
   input wire logic wrEn,
   input wire logic rdEn,
   input wire logic readSelHere,
   // status
   output logic fullN,
   output logic almostFull,
   output logic notAlmostEmpty
);
   // ==========================================================
   // thresholds, counted in the narrower word
   logic [CNT_W-1:0] count_q, count_d;
   logic [CNT_W-1:0] wrStep, rdStep;
   logic [CNT_W-1:0] baseFull, baseAf, baseAe;
   logic [CNT_W-1:0] thrFull, thrAf, thrAe;
   logic firstSame_q, same, wrOk, rdOk;

   // a word already fallen through on the read side shifts every bound
   assign same = firstSame_q && (busMatch != MATCH_IN18_OUT9);

   // equal widths give the base, mixed widths double it
   always_comb begin
      baseFull = same ? CNT_W'(DEPTH + 1) : CNT_W'(DEPTH);
      baseAf = baseFull - afOffset; // see R1 see R2
      baseAe = aeOffset + (same ? 13'h0002 : 13'h0001); // see R8 see R9
      if (busMatch == MATCH_EQUAL) begin
         thrFull = baseFull;
         thrAf = baseAf;
         thrAe = baseAe;
      end else begin
         thrFull = {baseFull[CNT_W-2:0], 1'b0};
         thrAf = {baseAf[CNT_W-2:0], 1'b0}; // see R3
         thrAe = {baseAe[CNT_W-2:0], 1'b0};
      end
   end

   // step sizes; overflow and underflow are simply refused
   assign wrStep = (busMatch == MATCH_IN18_OUT9) ? 13'h0002 : 13'h0001;
   assign rdStep = (busMatch == MATCH_IN9_OUT18) ? 13'h0002 : 13'h0001;
   assign wrOk = wrEn && (count_q < thrFull);
   assign rdOk = rdEn && (count_q >= rdStep);
   assign count_d = count_q + (wrOk ? wrStep : 13'h0000)
      - (rdOk ? rdStep : 13'h0000);

   // fill level
   always_ff @(posedge clk_sys) begin
      if (srst || clear) begin
         count_q <= '0;
      end else begin
         count_q <= count_d;
      end
   end

   // remember whether the read port sat here at the first write
   always_ff @(posedge clk_sys) begin
      if (srst || clear) begin
         firstSame_q <= 1'b0;
      end else if (wrOk && count_q == '0) begin
         firstSame_q <= readSelHere;
      end
   end

   // full falls on the filling edge, rises one cycle late after a read
   always_ff @(posedge clk_sys) begin
      if (srst || clear) begin
         fullN <= 1'b1;
      end else begin
         fullN <= !((count_d >= thrFull)
            || (count_q >= thrFull && !fullN)); // see R13
      end
   end

   // first of the two flag stages; the device adds the second
   always_ff @(posedge clk_sys) begin
      if (srst || clear) begin
         almostFull <= 1'b0;
         notAlmostEmpty <= 1'b0;
      end else begin
         almostFull <= count_q >= thrAf; // see R5 see R6
         notAlmostEmpty <= count_q >= thrAe; // see R11
      end
   end
endmodule
`default_nettype wire

//--- logic/queue_flag_device.sv
// Contract
// R1 - same queue equal widths: flag after D+1-m
// R2 - write-only or 18-to-9: flag after D-m
// R3 - 9-to-18: flag after twice D+1-m
// R4 - full offset 8 or 128 by strap
// R5 - almost-full falls two cycles after write
// R6 - almost-full rises one cycle after skew
// R7 - full bus bit shares discrete flag latency
// R8 - almost-empty rises after n+2, n+1, twice
// R9 - bus bit write-only: n+1, or twice
// R10 - empty offset 8 or 128 by strap
// R11 - almost-empty falls two cycles after read
// R12 - empty bus bit shares discrete latency
// R13 - full falls on filling write edge
// R14 - per-queue status, selected queue drives flags
// R15 - flag mode strap: direct low, polled high
// R16 - eight queues or fewer: fixed bit mapping
// R17 - strobe captures quadrant, bus next cycle
// R18 - quadrant codes map four queue octets
// R19 - switching bit may lag, flag correct
// R20 - controller never selects queue and quadrant together
// R21 - top address bits must match identity
// R22 - prefer polled mode for small single device
// R23 - flags active low, clocked updates only
// R24 - unmatched device floats its status buses
`timescale 1ns/1ns
`default_nettype none
module queue_flag_device
   import queue_flag_pkg::*;
#(
   parameter int DEPTH = DEPTH_DEFAULT
) (
   // clock and reset
   input wire logic clk_sys,
   input wire logic srst,
   // link to the controller
   queue_flag_if.device link,
   // static identity straps
   input wire logic [ID_W-1:0] deviceIdentity
);
   // ==========================================================
   // configuration caught while master reset is held
   logic offsetHigh_q, polled_q;
   bus_match_t match_q;
   logic [QCNT_W-1:0] queueCount_q;
   logic clearAll;
   logic [CNT_W-1:0] afOffset, aeOffset;

   assign clearAll = !link.masterResetN;

   // straps are latched by the clock, never by the reset itself
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         offsetHigh_q <= 1'b0;
         polled_q <= 1'b0;
         match_q <= MATCH_EQUAL;
         queueCount_q <= '0;
      end else if (clearAll) begin
         offsetHigh_q <= link.defaultOffsetSelect;
         polled_q <= link.flagBusModeSelect; // see R15
         match_q <= link.busMatch;
         queueCount_q <= link.queueCount;
      end
   end

   // one offset pair for every queue, fixed by the strap
   assign afOffset = offsetHigh_q ? OFFSET_HIGH : OFFSET_LOW; // see R4
   assign aeOffset = offsetHigh_q ? OFFSET_HIGH : OFFSET_LOW; // see R10

   // ==========================================================
   // queue selection on both ports
   logic wrIdOk, rdIdOk;
   logic [QUEUE_W-1:0] writeSel_q, readSel_q;
   logic writeOwn_q, readOwn_q;

   // only the addressed device of a shared bus reacts
   assign wrIdOk = link.writeQueueAddr[ADDR_W-1 -: ID_W]
      == deviceIdentity; // see R21
   assign rdIdOk = link.readQueueAddr[ADDR_W-1 -: ID_W]
      == deviceIdentity; // see R21

   // write port queue; ownership drops when another device is picked
   always_ff @(posedge clk_sys) begin
      if (srst || clearAll) begin
         writeSel_q <= '0;
         writeOwn_q <= 1'b0;
      end else if (link.writeAddrEnable) begin
         writeSel_q <= link.writeQueueAddr[QUEUE_W-1:0];
         writeOwn_q <= wrIdOk;
      end
   end

   // read port queue
   always_ff @(posedge clk_sys) begin
      if (srst || clearAll) begin
         readSel_q <= '0;
         readOwn_q <= 1'b0;
      end else if (link.readAddrEnable) begin
         readSel_q <= link.readQueueAddr[QUEUE_W-1:0];
         readOwn_q <= rdIdOk;
      end
   end

   // ==========================================================
   // per-queue counters
   logic [QUEUES-1:0] fullN, almostFull, notAlmostEmpty;

   // every queue keeps its own status, selected or not
   for (genvar q = 0; q < QUEUES; q++) begin : g_queue
      queue_flag_counter #(
         .DEPTH(DEPTH)
      ) u_counter (
         .clk_sys(clk_sys),
         .srst(srst),
         .clear(clearAll),
         .busMatch(match_q),
         .afOffset(afOffset),
         .aeOffset(aeOffset),
         .wrEn(link.writeEnable && writeOwn_q
            && writeSel_q == QUEUE_W'(q)), // see R14
         .rdEn(link.readEnable && readOwn_q
            && readSel_q == QUEUE_W'(q)),
         .readSelHere(readOwn_q && readSel_q == QUEUE_W'(q)),
         .fullN(fullN[q]),
         .almostFull(almostFull[q]),
         .notAlmostEmpty(notAlmostEmpty[q])
      );
   end

   // ==========================================================
   // discrete flags of the selected queues
   logic almostFullFlagN_q, almostEmptyFlagN_q;

   // full is already a flop per queue, so no extra stage here
   assign link.queueFullFlagN = writeOwn_q ? fullN[writeSel_q] : 1'b1;

   // second stage gives the two-cycle flag latency
   always_ff @(posedge clk_sys) begin
      if (srst || clearAll) begin
         almostFullFlagN_q <= 1'b1;
         almostEmptyFlagN_q <= 1'b0;
      end else begin
         almostFullFlagN_q <= !(writeOwn_q
            && almostFull[writeSel_q]); // see R5 see R23
         almostEmptyFlagN_q <= readOwn_q
            && notAlmostEmpty[readSel_q]; // see R11 see R23
      end
   end

   assign link.almostFullFlagN = almostFullFlagN_q;
   assign link.almostEmptyFlagN = almostEmptyFlagN_q;

   // ==========================================================
   // quadrant selection for the two status buses
   logic [QUAD_W-1:0] fullQuad_q, emptyQuad_q, fullQuad, emptyQuad;
   logic fullOe_q, emptyOe_q, dedicated;

   // full side: strobe captures the low address bits
   always_ff @(posedge clk_sys) begin
      if (srst || clearAll) begin
         fullQuad_q <= '0;
         fullOe_q <= 1'b0;
      end else if (polled_q) begin
         fullQuad_q <= fullQuad_q + 2'h1;
         fullOe_q <= 1'b1;
      end else if (link.fullQuadStrobe) begin
         fullQuad_q <= link.writeQueueAddr[QUAD_W-1:0]; // see R17
         fullOe_q <= wrIdOk; // see R24
      end
   end

   // empty side mirrors the full side on the read address
   always_ff @(posedge clk_sys) begin
      if (srst || clearAll) begin
         emptyQuad_q <= '0;
         emptyOe_q <= 1'b0;
      end else if (polled_q) begin
         emptyQuad_q <= emptyQuad_q + 2'h1;
         emptyOe_q <= 1'b1;
      end else if (link.emptyQuadStrobe) begin
         emptyQuad_q <= link.readQueueAddr[QUAD_W-1:0];
         emptyOe_q <= rdIdOk; // see R24
      end
   end

   // few queues: each owns a bit, the quadrant is ignored
   assign dedicated = queueCount_q <= DEDICATED_MAX; // see R16
   assign fullQuad = dedicated ? '0 : fullQuad_q;
   assign emptyQuad = dedicated ? '0 : emptyQuad_q;

   // ==========================================================
   // status bus bits
   logic [BUS_W-1:0] fullBusN_q, emptyBusN_q;

   // a bit whose queue moved on the switch edge may trail one cycle
   for (genvar b = 0; b < BUS_W; b++) begin : g_bus
      always_ff @(posedge clk_sys) begin
         if (srst || clearAll) begin
            fullBusN_q[b] <= 1'b1;
            emptyBusN_q[b] <= 1'b0;
         end else begin
            fullBusN_q[b] <= !almostFull[{fullQuad, 3'(b)}]; // see R7 see R18
            emptyBusN_q[b] <= notAlmostEmpty[{emptyQuad, 3'(b)}]; // see R12
         end
      end
   end

   assign link.almostFullStatusBusN = fullBusN_q; // see R19
   assign link.almostEmptyStatusBusN = emptyBusN_q;
   assign link.almostFullBusOe = fullOe_q;
   assign link.almostEmptyBusOe = emptyOe_q;
endmodule
`default_nettype wire

//--- logic/queue_flag_host.sv
`timescale 1ns/1ns
`default_nettype none
module queue_flag_host
   import queue_flag_pkg::*;
(
   // clock and reset
   input wire logic clk_sys,
   input wire logic srst,
   // AHB-Lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   // link to the device
   queue_flag_if.host link
);
   // ==========================================================
   // bus slave, zero wait states
   logic wrPending_q;
   logic [7:0] wrAddr_q;
   logic [31:0] config_q;
   logic addrPhase;

   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign addrPhase = hsel && hready && htrans[1];

   // address phase remembered for the write data phase
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         wrPending_q <= 1'b0;
         wrAddr_q <= '0;
      end else begin
         wrPending_q <= addrPhase && hwrite && hsize == 3'h2;
         wrAddr_q <= haddr[7:0];
      end
   end

   // read data captured at the address phase, unmapped reads zero
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         hrdata <= '0;
      end else if (addrPhase && !hwrite) begin
         unique case (haddr[7:0])
            REG_CONFIG: hrdata <= config_q;
            REG_FLAGS: hrdata <= {26'h0, link.almostEmptyBusOe,
               link.almostFullBusOe, 1'b0, link.almostEmptyFlagN,
               link.almostFullFlagN, link.queueFullFlagN};
            REG_BUSES: hrdata <= {16'h0, link.almostEmptyStatusBusN,
               link.almostFullStatusBusN};
            default: hrdata <= '0;
         endcase
      end
   end

   // configuration; master reset held from reset until software lifts it
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         config_q <= CONFIG_RESET;
      end else if (wrPending_q && wrAddr_q == REG_CONFIG) begin
         config_q <= hwdata;
      end
   end

   assign link.masterResetN = !config_q[CFG_RESET_BIT];
   assign link.defaultOffsetSelect = config_q[CFG_DF_BIT];
   assign link.flagBusModeSelect = config_q[CFG_FM_BIT];
   assign link.busMatch = bus_match_t'(config_q[CFG_MATCH_LSB +: 2]);
   assign link.queueCount = config_q[CFG_QCNT_LSB +: QCNT_W];

   // ==========================================================
   // one command word becomes one link cycle
   cmd_op_t op;
   logic cmdValid;
   logic [ADDR_W-1:0] cmdAddr;

   assign cmdValid = wrPending_q && wrAddr_q == REG_COMMAND;
   assign op = cmd_op_t'(hwdata[CMD_OP_LSB +: 3]);
   assign cmdAddr = hwdata[CMD_ADDR_LSB +: ADDR_W];

   // one op per cycle keeps queue and quadrant selects apart
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         link.writeQueueAddr <= '0;
         link.readQueueAddr <= '0;
         link.writeAddrEnable <= 1'b0;
         link.writeEnable <= 1'b0;
         link.fullQuadStrobe <= 1'b0;
         link.readAddrEnable <= 1'b0;
         link.readEnable <= 1'b0;
         link.emptyQuadStrobe <= 1'b0;
      end else begin
         link.writeAddrEnable <= 1'b0;
         link.writeEnable <= 1'b0;
         link.fullQuadStrobe <= 1'b0;
         link.readAddrEnable <= 1'b0;
         link.readEnable <= 1'b0;
         link.emptyQuadStrobe <= 1'b0;
         if (cmdValid) begin
            unique case (op)
               OP_NONE: begin
               end
               OP_WRITE_SELECT: begin
                  link.writeQueueAddr <= cmdAddr;
                  link.writeAddrEnable <= 1'b1; // see R20
               end
               OP_FULL_QUAD: begin
                  link.writeQueueAddr <= cmdAddr; // see R17 see R21
                  link.fullQuadStrobe <= 1'b1;
               end
               OP_WRITE: begin
                  link.writeEnable <= 1'b1;
               end
               OP_READ_SELECT: begin
                  link.readQueueAddr <= cmdAddr;
                  link.readAddrEnable <= 1'b1;
               end
               OP_READ: begin
                  link.readEnable <= 1'b1;
               end
               OP_EMPTY_QUAD: begin
                  link.readQueueAddr <= cmdAddr; // see R21
                  link.emptyQuadStrobe <= 1'b1;
               end
               OP_WRITE_AND_QUAD: begin
                  link.writeQueueAddr <= cmdAddr; // see R20
                  link.writeEnable <= 1'b1;
                  link.fullQuadStrobe <= 1'b1;
               end
            endcase
         end
      end
   end
endmodule
`default_nettype wire

//--- testbench/queue_flag_chk.sv
`timescale 1ns/1ns
`default_nettype none
module queue_flag_chk
   import queue_flag_pkg::*;
#(
   parameter logic [ID_W-1:0] DEV_ID = 3'h0
) (
   // clock and reset
   input wire logic clk_sys,
   input wire logic srst,
   // straps
   input wire logic masterResetN,
   input wire logic flagBusModeSelect,
   // write side
   input wire logic [ADDR_W-1:0] writeQueueAddr,
   input wire logic writeAddrEnable,
   input wire logic writeEnable,
   input wire logic fullQuadStrobe,
   // read side
   input wire logic [ADDR_W-1:0] readQueueAddr,
   input wire logic readAddrEnable,
   input wire logic readEnable,
   input wire logic emptyQuadStrobe,
   // device flags
   input wire logic queueFullFlagN,
   input wire logic almostFullFlagN,
   input wire logic almostEmptyFlagN,
   input wire logic [BUS_W-1:0] almostFullStatusBusN,
   input wire logic almostFullBusOe,
   input wire logic [BUS_W-1:0] almostEmptyStatusBusN,
   input wire logic almostEmptyBusOe
);
   // ==========================================================
   // helper terms
   logic linkBusy;
   logic direct;
   // any pulse that may move a flag within the next three edges
   assign linkBusy = writeEnable | readEnable | writeAddrEnable |
      readAddrEnable | fullQuadStrobe | emptyQuadStrobe | !masterResetN;
   assign direct = masterResetN & !flagBusModeSelect;

   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (srst);

   // ==========================================================
   // assertions
   full_fall_a: assert property (
      $fell(queueFullFlagN) |-> $past(writeEnable) || $past(writeAddrEnable))
      else $error("full flag fell with no write or queue switch");
   full_rise_a: assert property (
      $rose(queueFullFlagN) |-> $past(readEnable, 2) ||
      $past(writeAddrEnable) || !$past(masterResetN) || !$past(masterResetN, 2))
      else $error("full flag rose at the wrong edge");
   af_fall_a: assert property (
      $fell(almostFullFlagN) |-> $past(writeEnable, 3) ||
      $past(writeAddrEnable) || $past(writeAddrEnable, 2) ||
      $past(writeAddrEnable, 3))
      else $error("almost-full fell not two edges after a write");
   ae_fall_a: assert property (
      $fell(almostEmptyFlagN) |-> $past(readEnable, 3) ||
      $past(readAddrEnable) || $past(readAddrEnable, 2) ||
      $past(readAddrEnable, 3) || !$past(masterResetN) ||
      !$past(masterResetN, 2) || !$past(masterResetN, 3))
      else $error("almost-empty fell not two edges after a read");
   oe_full_a: assert property (
      fullQuadStrobe && direct && writeQueueAddr[7:5] != DEV_ID
      |=> !almostFullBusOe)
      else $error("full bus driven for another identity");
   oe_empty_a: assert property (
      emptyQuadStrobe && direct && readQueueAddr[7:5] == DEV_ID
      |=> almostEmptyBusOe)
      else $error("empty bus not driven for own identity");
   poll_oe_a: assert property (
      (masterResetN && flagBusModeSelect) [*3]
      |-> almostFullBusOe && almostEmptyBusOe)
      else $error("polled mode buses not driven");
   flag_quiet_a: assert property (
      (!linkBusy) [*4] |=> $stable(queueFullFlagN) &&
      $stable(almostFullFlagN) && $stable(almostEmptyFlagN))
      else $error("flag moved with an idle link");
   bus_quiet_a: assert property (
      (!linkBusy && direct) [*4] |=> $stable(almostFullStatusBusN) &&
      $stable(almostEmptyStatusBusN))
      else $error("status bus moved with an idle link");
endmodule
`default_nettype wire

//--- testbench/queue_almost_flag_status_test.sv
`timescale 1ns/1ns
`default_nettype none
module queue_almost_flag_status_test;
   import queue_flag_pkg::*;
   // ==========================================================
   // short queues keep every fill loop cheap
   localparam int D = 160;
   localparam logic [ID_W-1:0] DEV_ID = 3'h5;
   logic clk_sys = 1'b0;
   logic srst = 1'b1;
   logic hsel = 1'b1;
   logic [31:0] haddr = 32'h0;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [2:0] hsize = 3'h2;
   logic [31:0] hwdata = 32'h0;
   logic hreadyout, hresp;
   logic [31:0] hrdata;
   logic [31:0] rdv;
   logic [15:0] busx;
   logic [2:0] fl;
   logic same;
   int ft, at, et, wq, q;
   int err_count = 0, cmp_count = 0;

   always #4 clk_sys = ~clk_sys;

   queue_flag_if link ();
   queue_flag_host u_queue_flag_host (.clk_sys(clk_sys), .srst(srst),
      .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
      .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .link(link));
   queue_flag_device #(.DEPTH(D)) u_queue_flag_device (.clk_sys(clk_sys),
      .srst(srst), .link(link), .deviceIdentity(DEV_ID));
   queue_flag_chk #(.DEV_ID(DEV_ID)) u_queue_flag_chk (.clk_sys(clk_sys),
      .srst(srst), .masterResetN(link.masterResetN),
      .flagBusModeSelect(link.flagBusModeSelect),
      .writeQueueAddr(link.writeQueueAddr),
      .writeAddrEnable(link.writeAddrEnable),
      .writeEnable(link.writeEnable), .fullQuadStrobe(link.fullQuadStrobe),
      .readQueueAddr(link.readQueueAddr),
      .readAddrEnable(link.readAddrEnable), .readEnable(link.readEnable),
      .emptyQuadStrobe(link.emptyQuadStrobe),
      .queueFullFlagN(link.queueFullFlagN),
      .almostFullFlagN(link.almostFullFlagN),
      .almostEmptyFlagN(link.almostEmptyFlagN),
      .almostFullStatusBusN(link.almostFullStatusBusN),
      .almostFullBusOe(link.almostFullBusOe),
      .almostEmptyStatusBusN(link.almostEmptyStatusBusN),
      .almostEmptyBusOe(link.almostEmptyBusOe));

   // ==========================================================
   // bus access
   task end_sim;
      $display("TB: %0d mismatches in %0d checks", err_count, cmp_count);
      if (err_count == 0 && cmp_count > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   // one single word transfer, held until the slave is ready
   task xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
      haddr <= {24'h0, a};
      htrans <= 2'h2;
      hwrite <= wr;
      @(posedge clk_sys);
      while (hreadyout !== 1'b1) @(posedge clk_sys);
      htrans <= 2'h0;
      hwdata <= d;
      @(posedge clk_sys);
      while (hreadyout !== 1'b1) @(posedge clk_sys);
      rdv = hrdata;
   endtask

   task expect_reg(input logic [7:0] a, input logic [31:0] exp,
      input logic [31:0] mask);
      xfer(1'b0, a, 32'h0);
      cmp_count++;
      if ((rdv & mask) !== (exp & mask) || hresp !== 1'b0) begin
         err_count++;
         $display("CHECK FAILED at %0t: reg %h read %h want %h", $time, a,
            rdv, exp);
      end
   endtask

   task cmd(input cmd_op_t op, input logic [7:0] a);
      xfer(1'b1, REG_COMMAND, {21'h0, op, a});
   endtask

   // flags land two edges after the link pulse; status reads later
   task settle;
      repeat (4) @(posedge clk_sys);
   endtask

   // ==========================================================
   // scenarios
   task check(input int c);
      settle();
      fl = {same & (c >= et), c < at, c < ft};
      busx = 16'h00FF;
      busx[wq] = c < at;
      busx[8 + wq] = c >= et;
      expect_reg(REG_FLAGS, {29'h0, fl}, 32'h7);
      expect_reg(REG_BUSES, {16'h0, busx}, 32'hFFFF);
   endtask

   task setup(input bus_match_t mt, input logic df, input logic fm,
      input int w);
      logic [31:0] cfg;
      cfg = {21'h0, fm ? 6'h08 : 6'h20, mt, fm, df, 1'b1};
      xfer(1'b1, REG_CONFIG, cfg);
      xfer(1'b1, REG_CONFIG, cfg & 32'hFFFF_FFFE);
      settle();
      expect_reg(REG_FLAGS, {26'h0, fm, fm, 4'h0}, 32'h30);
      wq = w;
      cmd(OP_WRITE_SELECT, {DEV_ID, 5'(w)});
      cmd(OP_READ_SELECT, {DEV_ID, 5'h0});
      cmd(OP_FULL_QUAD, {DEV_ID, 5'h0});
      cmd(OP_EMPTY_QUAD, {DEV_ID, 5'h0});
   endtask

   // fill past full (refused), then drain past empty if asked
   task run(input bus_match_t mt, input logic df, input int w,
      input logic drain);
      int o, c;
      o = df ? 128 : 8;
      setup(mt, df, 1'b0, w);
      same = (w == 0);
      ft = (same && mt != MATCH_IN18_OUT9) ? D + 1 : D;
      et = (same && mt != MATCH_IN18_OUT9) ? o + 2 : o + 1;
      at = ft - o;
      if (mt == MATCH_IN9_OUT18) begin
         ft = 2 * ft;
         at = 2 * at;
         et = 2 * et;
      end
      for (c = 1; c <= ft + 1; c++) begin
         cmd(OP_WRITE, {DEV_ID, 5'(w)});
         check(c > ft ? ft : c);
      end
      if (drain) begin
         for (c = ft - 1; c >= -1; c--) begin
            cmd(OP_READ, {DEV_ID, 5'h0});
            check(c < 0 ? 0 : c);
         end
      end
   endtask

   initial begin
      repeat (20) @(posedge clk_sys);
      srst <= 1'b0;
      @(posedge clk_sys);
      expect_reg(REG_CONFIG, CONFIG_RESET, 32'hFFFF_FFFF);
      xfer(1'b1, 8'h10, 32'hFFFF_FFFF);
      expect_reg(8'h10, 32'h0, 32'hFFFF_FFFF);
      expect_reg(REG_CONFIG, CONFIG_RESET, 32'hFFFF_FFFF);
      run(MATCH_EQUAL, 1'b0, 0, 1'b1);
      run(MATCH_EQUAL, 1'b1, 0, 1'b0);
      run(MATCH_IN18_OUT9, 1'b0, 0, 1'b0);
      run(MATCH_IN9_OUT18, 1'b1, 0, 1'b0);
      run(MATCH_EQUAL, 1'b0, 1, 1'b0);
      for (q = 0; q < 4; q++) begin
         cmd(OP_WRITE_AND_QUAD, {DEV_ID, 5'(q)});
         cmd(OP_EMPTY_QUAD, {DEV_ID, 5'(q)});
         settle();
         expect_reg(REG_BUSES, q == 0 ? 32'h02FD : 32'h00FF, 32'hFFFF);
      end
      cmd(OP_FULL_QUAD, {~DEV_ID, 5'h0});
      settle();
      expect_reg(REG_FLAGS, 32'h20, 32'h30);
      setup(MATCH_EQUAL, 1'b0, 1'b1, 0);
      for (q = 0; q < 11; q++) begin
         cmd(q == 10 ? OP_NONE : OP_WRITE, {DEV_ID, 5'h0});
      end
      settle();
      expect_reg(REG_BUSES, 32'h01FF, 32'hFFFF);
      end_sim();
   end

   // cut a hang short
   initial begin
      repeat (40000) @(posedge clk_sys);
      err_count++;
      $display("CHECK FAILED at %0t: watchdog expired", $time);
      end_sim();
   end
endmodule
`default_nettype wire
